//--- src/ferc_defines.svh
`ifndef FERC_DEFINES_SVH
`define FERC_DEFINES_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define FERC_REF_OFS      8'h00
`define FERC_CAP_OFS      8'h04
`define FERC_CTRL_OFS     8'h08
`define FERC_STAT_OFS     8'h0c
`define FERC_LALIGN_OFS   8'h10
`define FERC_LFRAME_OFS   8'h14
`define FERC_IMASK_OFS    8'h18
`define FERC_ISTAT_OFS    8'h1c

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define FERC_CTRL_CONT_BIT  0
`define FERC_CTRL_RUN_BIT   1
`define FERC_CTRL_IEN_BIT   2
`define FERC_STAT_FULL_BIT  0
`define FERC_EV_CAPT_BIT    0
`define FERC_EV_OVR_BIT     1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define FERC_REF_RST    16'h0000
`define FERC_CTRL_RST   3'h0
`define FERC_EV_RST     2'h0

// ----------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------
`define FERC_RESP_OKAY    2'h0
`define FERC_RESP_SLVERR  2'h2

`endif

//--- src/ferc_pkg.sv
package ferc_pkg;

    typedef enum logic [1:0] {
        FERC_IDLE,
        FERC_COUNT,
        FERC_HALTED
    } ferc_state_t;

endpackage

//--- src/ferc_top.sv
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "ferc_defines.svh"

module ferc_top #(
    parameter int CNT_W = 16
) (
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic        align_sync_in,
    input  wire logic        frame_start_in,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             adjust_irq_n,
    output logic             event_irq
);

    if (CNT_W != 16) begin : g_width_check
        $error("ferc_top: registers are 16 bits wide");
    end

    // ------------------------------------------------------------
    // input synchronisers and edge detection
    // ------------------------------------------------------------
    // three flops: two to resolve metastability, the third for the edge
    logic [2:0] align_sq;
    logic [2:0] frame_sq;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            align_sq <= 3'h0;
            frame_sq <= 3'h0;
        end else begin
            align_sq <= {align_sq[1:0], align_sync_in};
            frame_sq <= {frame_sq[1:0], frame_start_in};
        end
    end
    // rising edge seen only between the second and third flop
    wire align_edge = align_sq[1] & ~align_sq[2];
    wire frame_edge = frame_sq[1] & ~frame_sq[2];

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [15:0] ref_q;
    logic [2:0]  ctrl_q;
    logic [15:0] cap_q;
    logic        full_q;
    logic [15:0] align_cnt_q;
    logic [15:0] frame_cnt_q;
    logic [1:0]  ev_q;
    logic [1:0]  imask_q;
    logic        irq_q;
    ferc_pkg::ferc_state_t state_q;

    wire run      = ctrl_q[`FERC_CTRL_RUN_BIT];
    wire cont     = ctrl_q[`FERC_CTRL_CONT_BIT];
    wire irq_en   = ctrl_q[`FERC_CTRL_IEN_BIT];

    // ------------------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------------------
    logic       aw_held_q;
    logic       w_held_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;

    assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held_q & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;

    wire aw_fire = s_axi_awvalid & s_axi_awready;
    wire w_fire  = s_axi_wvalid & s_axi_wready;
    wire ar_fire = s_axi_arvalid & s_axi_arready;

    wire        aw_have = aw_held_q | aw_fire;
    wire        w_have  = w_held_q | w_fire;
    wire        wr_go   = aw_have & w_have & ~s_axi_bvalid;
    wire [7:0]  wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
    wire [31:0] wr_data = w_held_q ? wdata_q : s_axi_wdata;
    wire [3:0]  wr_strb = w_held_q ? wstrb_q : s_axi_wstrb;

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0]  strb);
        merge16 = {strb[1] ? data[15:8] : old[15:8],
                   strb[0] ? data[7:0]  : old[7:0]};
    endfunction

    function automatic logic known_addr(input logic [7:0] a);
        known_addr = (a == `FERC_REF_OFS)    || (a == `FERC_CAP_OFS)  ||
                     (a == `FERC_CTRL_OFS)   || (a == `FERC_STAT_OFS) ||
                     (a == `FERC_LALIGN_OFS) || (a == `FERC_LFRAME_OFS) ||
                     (a == `FERC_IMASK_OFS)  || (a == `FERC_ISTAT_OFS);
    endfunction

    wire wr_ref   = wr_go && wr_addr == `FERC_REF_OFS;
    wire wr_ctrl  = wr_go && wr_addr == `FERC_CTRL_OFS;
    wire wr_imask = wr_go && wr_addr == `FERC_IMASK_OFS;
    wire wr_istat = wr_go && wr_addr == `FERC_ISTAT_OFS;
    wire [15:0] ctrl_new = merge16({13'h0, ctrl_q}, wr_data, wr_strb);
    wire [15:0] ref_new  = merge16(ref_q, wr_data, wr_strb);

    // a read of the capture register is what services a capture
    wire cap_read = ar_fire && s_axi_araddr == `FERC_CAP_OFS;

    logic [15:0] rd_mux;
    always_comb begin
        case (s_axi_araddr)
            `FERC_REF_OFS:    rd_mux = ref_q;
            `FERC_CAP_OFS:    rd_mux = cap_q;
            `FERC_CTRL_OFS:   rd_mux = {13'h0, ctrl_q};
            `FERC_STAT_OFS:   rd_mux = {15'h0, full_q};
            `FERC_LALIGN_OFS: rd_mux = align_cnt_q;
            `FERC_LFRAME_OFS: rd_mux = frame_cnt_q;
            `FERC_IMASK_OFS:  rd_mux = {14'h0, imask_q};
            `FERC_ISTAT_OFS:  rd_mux = {14'h0, ev_q};
            default:          rd_mux = 16'h0000;
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            aw_held_q    <= 1'b0;
            w_held_q     <= 1'b0;
            awaddr_q     <= 8'h00;
            wdata_q      <= 32'h0;
            wstrb_q      <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `FERC_RESP_OKAY;
        end else begin
            if (aw_fire) begin
                awaddr_q <= s_axi_awaddr;
            end
            if (w_fire) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            aw_held_q <= aw_have & ~wr_go;
            w_held_q  <= w_have & ~wr_go;
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= known_addr(wr_addr) ? `FERC_RESP_OKAY
                                                    : `FERC_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= `FERC_RESP_OKAY;
        end else if (ar_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {16'h0, rd_mux};
            s_axi_rresp  <= known_addr(s_axi_araddr) ? `FERC_RESP_OKAY
                                                     : `FERC_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // measurement control
    // ------------------------------------------------------------
    // completion: the align edge that makes the tally reach the reference
    wire counting = (state_q == ferc_pkg::FERC_COUNT);
    wire done     = counting && align_edge &&
                    (align_cnt_q == ref_q - 16'h0001);

    ferc_pkg::ferc_state_t state_d;
    always_comb begin
        state_d = state_q;
        case (state_q)
            ferc_pkg::FERC_IDLE:
                if (ref_q != 16'h0000) begin
                    state_d = ferc_pkg::FERC_COUNT;
                end
            ferc_pkg::FERC_COUNT:
                if (ref_q == 16'h0000) begin
                    state_d = ferc_pkg::FERC_IDLE;
                end else if (done && !cont) begin
                    state_d = ferc_pkg::FERC_HALTED;
                end
            ferc_pkg::FERC_HALTED:
                if (cap_read || cont) begin
                    state_d = ferc_pkg::FERC_IDLE;
                end
            default: state_d = ferc_pkg::FERC_IDLE;
        endcase
        if (!run) begin
            state_d = ferc_pkg::FERC_IDLE;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ref_q   <= `FERC_REF_RST;
            ctrl_q  <= `FERC_CTRL_RST;
            imask_q <= `FERC_EV_RST;
            state_q <= ferc_pkg::FERC_IDLE;
        end else begin
            state_q <= state_d;
            if (wr_ref) begin
                ref_q <= ref_new;
            end
            if (wr_ctrl) begin
                ctrl_q <= ctrl_new[2:0];
            end
            if (wr_imask) begin
                imask_q <= wr_data[1:0];
            end
        end
    end

    // counters: cleared on completion so the completing edge starts afresh
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            align_cnt_q <= 16'h0000;
            frame_cnt_q <= 16'h0000;
            cap_q       <= 16'h0000;
        end else if (!run) begin
            align_cnt_q <= 16'h0000;
            frame_cnt_q <= 16'h0000;
            cap_q       <= 16'h0000;
        end else if (done) begin
            align_cnt_q <= 16'h0000;
            frame_cnt_q <= 16'h0000;
            // a frame edge in the closing cycle still belongs to this run
            cap_q       <= frame_cnt_q + {15'h0, frame_edge};
        end else if (counting) begin
            align_cnt_q <= align_cnt_q + {15'h0, align_edge};
            frame_cnt_q <= frame_cnt_q + {15'h0, frame_edge};
        end
    end

    // ------------------------------------------------------------
    // full flag, interrupts
    // ------------------------------------------------------------
    // a capture landing with a read of the old value keeps the flag set
    wire ovr_ev = done & full_q & ~cap_read;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            full_q <= 1'b0;
            irq_q  <= 1'b0;
            ev_q   <= `FERC_EV_RST;
        end else begin
            if (!run) begin
                full_q <= 1'b0;
                irq_q  <= 1'b0;
            end else if (done) begin
                full_q <= 1'b1;
                irq_q  <= irq_en;
            end else if (cap_read) begin
                full_q <= 1'b0;
                irq_q  <= 1'b0;
            end
            ev_q <= (wr_istat ? ev_q & ~wr_data[1:0] : ev_q)
                    | {ovr_ev, done};
        end
    end

    assign adjust_irq_n = ~irq_q;
    assign event_irq    = |(ev_q & imask_q);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // a completion that the run bit lets through to the capture
    sequence s_complete;
        run && done;
    endsequence

    property p_capture_loads;
        @(posedge sys_clk) disable iff (!nrst)
        s_complete |=> full_q && cap_q == $past(frame_cnt_q)
                       + {15'h0, $past(frame_edge)};
    endproperty
    a_capture_loads: assert property (p_capture_loads)
        else $error("capture not loaded on completion");
    property p_halt_stays;
        @(posedge sys_clk) disable iff (!nrst)
        (run && done && !cont && !cap_read) |=>
            state_q == ferc_pkg::FERC_HALTED;
    endproperty
    a_halt_stays: assert property (p_halt_stays)
        else $error("halt mode did not stop");
    property p_halt_read_restarts;
        @(posedge sys_clk) disable iff (!nrst)
        (state_q == ferc_pkg::FERC_HALTED && cap_read && run) |=>
            state_q == ferc_pkg::FERC_IDLE;
    endproperty
    a_halt_read_restarts: assert property (p_halt_read_restarts)
        else $error("capture read did not restart");
    property p_irq_follows;
        @(posedge sys_clk) disable iff (!nrst)
        s_complete |=> adjust_irq_n == !$past(irq_en);
    endproperty
    a_irq_follows: assert property (p_irq_follows)
        else $error("interrupt does not follow enable");
    property p_irq_read_release;
        @(posedge sys_clk) disable iff (!nrst)
        (cap_read && !done) |=> adjust_irq_n;
    endproperty
    a_irq_read_release: assert property (p_irq_read_release)
        else $error("interrupt held after capture read");
    property p_run_clear;
        @(posedge sys_clk) disable iff (!nrst)
        !run |=> cap_q == 16'h0000 && align_cnt_q == 16'h0000 &&
                 frame_cnt_q == 16'h0000 && adjust_irq_n && !full_q;
    endproperty
    a_run_clear: assert property (p_run_clear)
        else $error("run clear did not reset block");
    property p_zero_ref;
        @(posedge sys_clk) disable iff (!nrst)
        (ref_q == 16'h0000) [*2] |-> !counting;
    endproperty
    a_zero_ref: assert property (p_zero_ref)
        else $error("counting with zero reference");
    property p_edge_counts;
        @(posedge sys_clk) disable iff (!nrst)
        (run && counting && !done && frame_edge) |=>
            frame_cnt_q == $past(frame_cnt_q) + 16'h0001;
    endproperty
    a_edge_counts: assert property (p_edge_counts)
        else $error("frame edge not counted");
    property p_counters_clear;
        @(posedge sys_clk) disable iff (!nrst)
        done |=> align_cnt_q == 16'h0000 && frame_cnt_q == 16'h0000;
    endproperty
    a_counters_clear: assert property (p_counters_clear)
        else $error("counters not cleared at completion");
endmodule

//--- dv/ferc_edge_src.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// far side: align-sync and frame-start sources
// ----------------------------------------------------------------
module ferc_edge_src (
    input  wire logic sys_clk,
    output logic      align_sync_in,
    output logic      frame_start_in
);
    initial begin
        align_sync_in = 1'b0;
        frame_start_in = 1'b0;
    end

    // each level stands 4 clocks, so both inputs stay 8x slower
    task automatic one_pulse(input logic is_align);
        @(posedge sys_clk);
        if (is_align) align_sync_in <= 1'b1;
        else frame_start_in <= 1'b1;
        repeat (4) @(posedge sys_clk);
        align_sync_in <= 1'b0;
        frame_start_in <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask

    // n align periods, k frame-start pulses ahead of each align pulse
    task automatic periods(input int n, input int k);
        repeat (n) begin
            repeat (k) one_pulse(1'b0);
            one_pulse(1'b1);
        end
    endtask
endmodule

//--- dv/tb.sv
`timescale 1ns/10ps
`include "ferc_defines.svh"
module tb;
    typedef struct packed {
        logic        wr;
        logic [7:0]  a;
        logic [31:0] d;
        logic [1:0]  resp;
        logic [31:0] exp;
    } ferc_row_t;

    logic        sys_clk, nrst, align_sync_in, frame_start_in;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, adjust_irq_n, event_irq;
    int          n_mismatch, n_checks;
    ferc_row_t   rows[18];

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    ferc_top #(.CNT_W(16)) i_dut (
        .sys_clk(sys_clk), .nrst(nrst), .align_sync_in(align_sync_in),
        .frame_start_in(frame_start_in), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .adjust_irq_n(adjust_irq_n), .event_irq(event_irq)
    );

    ferc_edge_src i_src (
        .sys_clk(sys_clk), .align_sync_in(align_sync_in),
        .frame_start_in(frame_start_in)
    );

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // sampled at the falling edge, acted on at the next rising edge
    task automatic axi(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [1:0] r,
                       output logic [31:0] q);
        logic ah, wh, dh;
        dh = 1'b0;
        @(posedge sys_clk);
        if (wr) begin
            s_axi_awaddr <= a;
            s_axi_awvalid <= 1'b1;
            s_axi_wdata <= d;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
        end else begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
        end
        // no cycle limit: a hung bus is left to the watchdog
        while (!dh) begin
            @(negedge sys_clk);
            ah = wr ? s_axi_awvalid && s_axi_awready
                    : s_axi_arvalid && s_axi_arready;
            wh = s_axi_wvalid && s_axi_wready;
            dh = wr ? s_axi_bvalid && s_axi_bready
                    : s_axi_rvalid && s_axi_rready;
            r = wr ? s_axi_bresp : s_axi_rresp;
            q = s_axi_rdata;
            @(posedge sys_clk);
            if (ah && wr) s_axi_awvalid <= 1'b0;
            if (ah && !wr) s_axi_arvalid <= 1'b0;
            if (wh) s_axi_wvalid <= 1'b0;
            if (dh) begin
                s_axi_bready <= 1'b0;
                s_axi_rready <= 1'b0;
            end
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        axi(1'b1, a, d, rsp, rdv);
        chk("bresp", {30'h0, `FERC_RESP_OKAY}, {30'h0, rsp});
    endtask

    task automatic rd(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
        axi(1'b0, a, 32'h0, rsp, rdv);
        chk(nm, e, rdv);
    endtask

    task automatic pin(input string nm, input logic e, input logic g);
        chk(nm, {31'h0, e}, {31'h0, g});
    endtask

    // three sync clocks plus margin before looking at results
    task automatic settle();
        repeat (6) @(posedge sys_clk);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge sys_clk);
        chk("watchdog", 32'h0, 32'h1);
        conclude();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        nrst = 1'b0;
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
        rows = '{
            '{1'b0, 8'h00, 32'h0, 2'h0, 32'h0},
            '{1'b0, 8'h04, 32'h0, 2'h0, 32'h0},
            '{1'b0, 8'h08, 32'h0, 2'h0, 32'h0},
            '{1'b0, 8'h0c, 32'h0, 2'h0, 32'h0},
            '{1'b0, 8'h10, 32'h0, 2'h0, 32'h0},
            '{1'b0, 8'h14, 32'h0, 2'h0, 32'h0},
            '{1'b0, 8'h18, 32'h0, 2'h0, 32'h0},
            '{1'b0, 8'h1c, 32'h0, 2'h0, 32'h0},
            '{1'b0, 8'h20, 32'h0, 2'h2, 32'h0},
            '{1'b1, 8'h00, 32'habcd1234, 2'h0, 32'h0},
            '{1'b0, 8'h00, 32'h0, 2'h0, 32'h1234},
            '{1'b1, 8'h00, 32'h0, 2'h0, 32'h0},
            '{1'b1, 8'h08, 32'hfffd, 2'h0, 32'h0},
            '{1'b0, 8'h08, 32'h0, 2'h0, 32'h5},
            '{1'b1, 8'h08, 32'h0, 2'h0, 32'h0},
            '{1'b1, 8'h20, 32'h1, 2'h2, 32'h0},
            '{1'b1, 8'h18, 32'h3, 2'h0, 32'h0},
            '{1'b0, 8'h18, 32'h0, 2'h0, 32'h3}};
        repeat (4) @(posedge sys_clk);
        nrst <= 1'b1;
        foreach (rows[i]) begin
            axi(rows[i].wr, rows[i].a, rows[i].d, rsp, rdv);
            chk("resp", {30'h0, rows[i].resp}, {30'h0, rsp});
            if (!rows[i].wr) chk("rdata", rows[i].exp, rdv);
        end
        $display("test register table done");
        wr(`FERC_REF_OFS, 32'h3);
        wr(`FERC_CTRL_OFS, 32'h6);
        i_src.periods(3, 2);
        settle();
        rd("full", `FERC_STAT_OFS, 32'h1);
        pin("adjust_irq_n", 1'b0, adjust_irq_n);
        pin("event_irq", 1'b1, event_irq);
        i_src.periods(1, 2);
        settle();
        rd("halted frame cnt", `FERC_LFRAME_OFS, 32'h0);
        rd("capture", `FERC_CAP_OFS, 32'h6);
        pin("adjust_irq_n", 1'b1, adjust_irq_n);
        rd("full", `FERC_STAT_OFS, 32'h0);
        i_src.periods(3, 1);
        settle();
        pin("adjust_irq_n", 1'b0, adjust_irq_n);
        wr(`FERC_CTRL_OFS, 32'h4);
        // the run clear lands one edge after the write is answered
        @(negedge sys_clk);
        pin("adjust_irq_n", 1'b1, adjust_irq_n);
        rd("capture", `FERC_CAP_OFS, 32'h0);
        rd("full", `FERC_STAT_OFS, 32'h0);
        rd("align cnt", `FERC_LALIGN_OFS, 32'h0);
        wr(`FERC_CTRL_OFS, 32'h6);
        i_src.periods(3, 1);
        settle();
        rd("capture", `FERC_CAP_OFS, 32'h3);
        rd("event status", `FERC_ISTAT_OFS, 32'h1);
        wr(`FERC_ISTAT_OFS, 32'h1);
        pin("event_irq", 1'b0, event_irq);
        $display("test halt mode done");
        wr(`FERC_CTRL_OFS, 32'h0);
        wr(`FERC_REF_OFS, 32'h2);
        wr(`FERC_CTRL_OFS, 32'h3);
        i_src.periods(2, 3);
        settle();
        pin("adjust_irq_n", 1'b1, adjust_irq_n);
        i_src.periods(2, 1);
        settle();
        rd("capture", `FERC_CAP_OFS, 32'h2);
        i_src.periods(1, 2);
        settle();
        rd("align cnt", `FERC_LALIGN_OFS, 32'h1);
        rd("frame cnt", `FERC_LFRAME_OFS, 32'h2);
        // second capture landed while the first was unread: overrun
        rd("overrun", `FERC_ISTAT_OFS, 32'h3);
        $display("test continuous mode done");
        wr(`FERC_CTRL_OFS, 32'h0);
        wr(`FERC_REF_OFS, 32'h0);
        wr(`FERC_CTRL_OFS, 32'h3);
        i_src.periods(2, 1);
        settle();
        rd("align cnt", `FERC_LALIGN_OFS, 32'h0);
        rd("capture", `FERC_CAP_OFS, 32'h0);
        $display("test zero reference done");
        wr(`FERC_REF_OFS, 32'h1);
        i_src.periods(1, 1);
        settle();
        rd("capture", `FERC_CAP_OFS, 32'h1);
        @(posedge sys_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        rd("capture", `FERC_CAP_OFS, 32'h0);
        rd("ctrl", `FERC_CTRL_OFS, 32'h0);
        pin("event_irq", 1'b0, event_irq);
        $display("test mid-run reset done");
        conclude();
    end
endmodule
